// ===== rtl/tob_bit_select.sv
`timescale 1ns/1ps
// Function
// - Sa4 select 0 passes Sa4 through, 1 takes it from bits buffer 1.
// - Automatic Sa6 sends 0011, 0001, 0010 on errors, else buffer 0 nibble.
// - Sa6 nibble goes out MSB first, in frames 1-7 and again in frames 9-15.
// - Sa7 select 0 passes Sa7 through, 1 takes it from bits buffer 1.
// - Sa8 select 0 passes Sa8 through, 1 takes it from bits buffer 1.
// - E-bit code 00 pass, 01 buffer 0, 10 automatic; 11 falls back to pass-through.
// - Automatic E-bit is 0 on receive CRC error, 1 when check passes.
// - Control A writes take effect at the next multiframe start, never mid-multiframe; control B writes do not reach the line.
module tob_bit_select
  import tob_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Processor register port
  input  wire logic [7:0] mpu_addr,
  input  wire logic       mpu_wr_en,
  input  wire logic [7:0] mpu_wr_data,
  input  wire logic       mpu_rd_en,
  output logic      [7:0] mpu_rd_data,
  // Software-loaded bits buffers
  input  wire tob_buf0_s  bits_buf0,
  input  wire tob_buf1_s  bits_buf1,
  // Receive-side check results
  input  wire logic       rx_ebit_error,
  input  wire logic       rx_crc_error,
  // PCM transmit stream in and out
  input  wire tob_pcm_s   pcm_in,
  output tob_pcm_s        pcm_out
);

  logic [7:0] ctrl_a_q;
  logic [6:0] ctrl_b_q;
  logic [7:0] active_q;
  tob_buf0_s  buf0_q;
  tob_buf1_s  buf1_q;
  logic [3:0] sa6_auto_q;
  logic [3:0] sa6_auto_d;
  logic [1:0] e_sent_q;
  logic [3:0] sa6_sent_q;
  tob_pcm_s   pcm_out_q;
  logic [7:0] rd_data_q;

  logic       mf_start;
  logic       odd_frame;
  logic [2:0] nfas_idx;
  logic [1:0] nib_idx;
  logic       hit;
  logic [1:0] cur_mode;
  logic       cur_buf;
  logic       cur_auto;
  logic       sel_bit;

  // Register writes land in a shadow copy; the line only sees the active copy
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ctrl_a_q <= CTRL_A_RESET;
      ctrl_b_q <= CTRL_B_RESET;
    end
    else if (mpu_wr_en)
    begin
      if (mpu_addr == ADDR_CTRL_A)
        ctrl_a_q <= mpu_wr_data;
      if (mpu_addr == ADDR_CTRL_B)
        ctrl_b_q <= mpu_wr_data[6:0];
    end
  end

  assign mf_start  = pcm_in.valid && pcm_in.ts0 && (pcm_in.frame == MF_FIRST_FRAME)
                     && (pcm_in.bitpos == 3'h0);
  assign odd_frame = pcm_in.frame[0];
  assign nfas_idx  = pcm_in.frame[3:1];
  assign nib_idx   = ~pcm_in.frame[2:1];

  // A write in the boundary cycle misses it: the old shadow is copied
  always_ff @(posedge core_clk)
  begin
    if (reset)
      active_q <= CTRL_A_RESET;
    else if (mf_start)
      active_q <= ctrl_a_q;
  end

  // Buffers and the Sa6 error nibble are frozen per multiframe so a nibble is never torn
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      buf0_q     <= '0;
      buf1_q     <= '0;
      sa6_auto_q <= 4'h0;
    end
    else if (mf_start)
    begin
      buf0_q     <= bits_buf0;
      buf1_q     <= bits_buf1;
      sa6_auto_q <= sa6_auto_d;
    end
  end

  always_comb
  begin
    if (rx_ebit_error && rx_crc_error)
      sa6_auto_d = SA6_BOTH_ERR;
    else if (rx_ebit_error)
      sa6_auto_d = SA6_E_ERR;
    else if (rx_crc_error)
      sa6_auto_d = SA6_CRC_ERR;
    else
      sa6_auto_d = bits_buf0.sa6;
  end

  // Pick mode and candidate bits for the overhead bit under the cursor
  always_comb
  begin
    hit      = 1'b0;
    cur_mode = SRC_PASS;
    cur_buf  = 1'b0;
    cur_auto = 1'b0;
    if (pcm_in.valid && pcm_in.ts0 && odd_frame)
    begin
      case (pcm_in.bitpos)
        TS0_SA4_BIT:
        begin
          hit      = 1'b1;
          cur_mode = {1'b0, active_q[SA4_SEL_POS]};
          cur_buf  = buf1_q.sa4[nfas_idx];
        end
        TS0_SA5_BIT:
        begin
          hit      = 1'b1;
          cur_mode = {1'b0, active_q[SA5_SEL_POS]};
          cur_buf  = buf0_q.sa5[nfas_idx];
        end
        TS0_SA6_BIT:
        begin
          hit      = 1'b1;
          cur_mode = active_q[SA6_SEL_LSB +: 2];
          cur_buf  = buf0_q.sa6[nib_idx];
          cur_auto = sa6_auto_q[nib_idx];
        end
        TS0_SA7_BIT:
        begin
          hit      = 1'b1;
          cur_mode = {1'b0, active_q[SA7_SEL_POS]};
          cur_buf  = buf1_q.sa7[nfas_idx];
        end
        TS0_SA8_BIT:
        begin
          hit      = 1'b1;
          cur_mode = {1'b0, active_q[SA8_SEL_POS]};
          cur_buf  = buf1_q.sa8[nfas_idx];
        end
        TS0_SI_BIT:
        begin
          if (pcm_in.frame == E1_FRAME || pcm_in.frame == E2_FRAME)
          begin
            hit      = 1'b1;
            cur_mode = active_q[E_SEL_LSB +: 2];
            cur_buf  = buf0_q.ebit[pcm_in.frame[1]];
            // Live CRC result, so each E-bit reports the latest submultiframe
            cur_auto = rx_crc_error ? E_AUTO_ERR : E_AUTO_OK;
          end
        end
        default:
        begin
          hit = 1'b0;
        end
      endcase
    end
  end

  tob_src_mux u_src_mux (
    .mode     (cur_mode),
    .pass_bit (pcm_in.data),
    .buf_bit  (cur_buf),
    .auto_bit (cur_auto),
    .sel_bit  (sel_bit)
  );

  // One cycle of latency; position fields travel with the bit
  always_ff @(posedge core_clk)
  begin
    if (reset)
      pcm_out_q <= '0;
    else
    begin
      pcm_out_q      <= pcm_in;
      pcm_out_q.data <= hit ? sel_bit : pcm_in.data;
    end
  end

  // Record what actually went out for read-back
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      e_sent_q   <= 2'h0;
      sa6_sent_q <= 4'h0;
    end
    else if (hit && pcm_in.bitpos == TS0_SI_BIT)
      e_sent_q[pcm_in.frame[1]] <= sel_bit;
    else if (hit && pcm_in.bitpos == TS0_SA6_BIT)
      sa6_sent_q[nib_idx] <= sel_bit;
  end

  // Registers outside this block read as zero here
  always_ff @(posedge core_clk)
  begin
    if (reset)
      rd_data_q <= 8'h00;
    else if (mpu_rd_en)
    begin
      case (mpu_addr)
        ADDR_CTRL_A: rd_data_q <= ctrl_a_q;
        ADDR_CTRL_B: rd_data_q <= {1'b0, ctrl_b_q};
        ADDR_MON_A:  rd_data_q <= {sa6_sent_q, 2'b00, e_sent_q};
        default:     rd_data_q <= 8'h00;
      endcase
    end
  end

  assign pcm_out     = pcm_out_q;
  assign mpu_rd_data = rd_data_q;

endmodule

// ===== include/tob_pkg.sv
package tob_pkg;

  // Register map
  localparam logic [7:0] ADDR_CTRL_A  = 8'h40;
  localparam logic [7:0] ADDR_CTRL_B  = 8'h41;
  localparam logic [7:0] ADDR_MON_A   = 8'h42;
  localparam logic [7:0] ADDR_E_COUNT = 8'h43;
  localparam logic [7:0] ADDR_INBAND  = 8'h45;
  localparam logic [7:0] ADDR_MON_B   = 8'h46;
  localparam logic [7:0] ADDR_MON_C   = 8'h47;

  // Reset values
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [6:0] CTRL_B_RESET = 7'h00;

  // Field positions in tx_overhead_source_ctrl_a
  localparam int SA4_SEL_POS = 0;
  localparam int SA5_SEL_POS = 1;
  localparam int SA6_SEL_LSB = 2;
  localparam int SA7_SEL_POS = 4;
  localparam int SA8_SEL_POS = 5;
  localparam int E_SEL_LSB   = 6;

  // Field positions in tx_overhead_monitor_a
  localparam int MON_E1_POS  = 0;
  localparam int MON_E2_POS  = 1;
  localparam int MON_SA6_LSB = 4;

  // Source codes
  typedef enum logic [1:0] {
    SRC_PASS    = 2'b00,
    SRC_BUF     = 2'b01,
    SRC_AUTO    = 2'b10,
    SRC_ILLEGAL = 2'b11
  } tob_src_e;

  // Automatic Sa6 nibbles
  localparam logic [3:0] SA6_BOTH_ERR = 4'h3;
  localparam logic [3:0] SA6_E_ERR    = 4'h1;
  localparam logic [3:0] SA6_CRC_ERR  = 4'h2;

  // Automatic E-bit values
  localparam logic E_AUTO_ERR = 1'b0;
  localparam logic E_AUTO_OK  = 1'b1;

  // Bit index within timeslot 0 (0 = first bit sent)
  localparam logic [2:0] TS0_SI_BIT  = 3'h0;
  localparam logic [2:0] TS0_SA4_BIT = 3'h3;
  localparam logic [2:0] TS0_SA5_BIT = 3'h4;
  localparam logic [2:0] TS0_SA6_BIT = 3'h5;
  localparam logic [2:0] TS0_SA7_BIT = 3'h6;
  localparam logic [2:0] TS0_SA8_BIT = 3'h7;

  // Multiframe positions
  localparam logic [3:0] MF_FIRST_FRAME = 4'h0;
  localparam logic [3:0] E1_FRAME       = 4'hd;
  localparam logic [3:0] E2_FRAME       = 4'hf;

  // One PCM bit with its position in the multiframe
  typedef struct packed {
    logic       valid;
    logic       data;
    logic       ts0;
    logic [3:0] frame;
    logic [2:0] bitpos;
  } tob_pcm_s;

  // Software-loaded bits buffers, one bit per odd frame except the Sa6 nibble and the two E-bits
  typedef struct packed {
    logic [7:0] sa4;
    logic [7:0] sa7;
    logic [7:0] sa8;
  } tob_buf1_s;

  typedef struct packed {
    logic [7:0] sa5;
    logic [3:0] sa6;
    logic [1:0] ebit;
  } tob_buf0_s;

endpackage

// ===== rtl/tob_src_mux.sv
`timescale 1ns/1ps
module tob_src_mux
  import tob_pkg::*;
(
  // Source choice
  input  wire logic [1:0] mode,
  // Candidate bits
  input  wire logic       pass_bit,
  input  wire logic       buf_bit,
  input  wire logic       auto_bit,
  // Chosen bit
  output logic            sel_bit
);

  always_comb
  begin
    case (mode)
      SRC_BUF:  sel_bit = buf_bit;
      SRC_AUTO: sel_bit = auto_bit;
      // Illegal code falls back to pass-through so the line stays predictable
      default:  sel_bit = pass_bit;
    endcase
  end

endmodule

// ===== testbench/tob_pcm_source.sv
`timescale 1ns/1ps
module tob_pcm_source
  import tob_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // Stream toward the block
  output tob_pcm_s  pcm_in
);
  logic [7:0] cnt_q = 8'h00;
  logic       run_q = 1'b0;
  // Short frames keep a multiframe at 256 bits: eight slot-0 bits, eight payload
  always @(negedge core_clk)
  begin
    run_q <= !reset;
    cnt_q <= run_q ? cnt_q + 8'h01 : 8'h00;
  end
  assign pcm_in = {run_q, cnt_q[0] ^ cnt_q[5] ^ cnt_q[7], ~cnt_q[3], cnt_q[7:4], cnt_q[2:0]};
endmodule

// ===== testbench/tob_bit_select_asserts.sv
`timescale 1ns/1ps
module tob_bit_select_asserts
  import tob_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [7:0] mpu_addr,
  input wire logic       mpu_wr_en,
  input wire logic [7:0] mpu_wr_data,
  input wire logic       mpu_rd_en,
  input wire logic [7:0] mpu_rd_data,
  input wire tob_pcm_s   pcm_in,
  input wire tob_pcm_s   pcm_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_payload_pass: assert property (pcm_in.valid && !pcm_in.ts0 |=>
    pcm_out.valid && pcm_out.data == $past(pcm_in.data)) else $error("payload bit altered");
  a_slot_fields: assert property (1'b1 |=> pcm_out[7:0] == $past(pcm_in[7:0]))
    else $error("position fields not delayed by one");
  a_even_frames: assert property (pcm_in.ts0 && !pcm_in.frame[0] |=>
    pcm_out.data == $past(pcm_in.data)) else $error("even frame slot 0 altered");
  a_low_slot_bits: assert property (pcm_in.ts0 && pcm_in.bitpos < TS0_SA4_BIT &&
    pcm_in.frame < E1_FRAME |=> pcm_out.data == $past(pcm_in.data)) else $error("Si altered");
  a_status_zero: assert property (mpu_rd_en && mpu_addr == ADDR_INBAND |=>
    mpu_rd_data == 8'h00) else $error("status read not zero");
  a_read_hold: assert property (!mpu_rd_en |=> $stable(mpu_rd_data))
    else $error("read data moved without read");
  a_ctrl_readback: assert property (mpu_wr_en && mpu_addr == ADDR_CTRL_A ##1 mpu_rd_en &&
    mpu_addr == ADDR_CTRL_A |=> mpu_rd_data == $past(mpu_wr_data, 2)) else $error("readback");
  a_ctrl_b_width: assert property (mpu_rd_en && mpu_addr == ADDR_CTRL_B |=> !mpu_rd_data[7])
    else $error("ctrl b bit 7 set");
endmodule
bind tob_bit_select tob_bit_select_asserts u_chk (.core_clk(core_clk), .reset(reset),
  .mpu_addr(mpu_addr), .mpu_wr_en(mpu_wr_en), .mpu_wr_data(mpu_wr_data),
  .mpu_rd_en(mpu_rd_en), .mpu_rd_data(mpu_rd_data), .pcm_in(pcm_in), .pcm_out(pcm_out));

// ===== testbench/tob_bit_select_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tob_bit_select_tb
  import tob_pkg::*;
;
  typedef struct packed {logic [7:0] ctrl; logic crc; logic eerr; logic [3:0] nib;} tob_row_s;
  localparam tob_row_s ROWS [8] = '{'{8'h00, 0, 0, 4'hc}, '{8'h33, 0, 0, 4'hc},
    '{8'h44, 0, 0, 4'hc}, '{8'h88, 1, 1, 4'h3}, '{8'h88, 1, 0, 4'h2}, '{8'h88, 0, 1, 4'h1},
    '{8'h88, 0, 0, 4'hc}, '{8'hcc, 1, 1, 4'h3}};
  logic       core_clk = 1'b0, reset = 1'b1, mpu_wr_en = 1'b0, mpu_rd_en = 1'b0;
  logic       rx_ebit_error = 1'b0, rx_crc_error = 1'b0, crc_q, rst_q;
  logic [7:0] mpu_addr = 8'h00, mpu_wr_data = 8'h00, mpu_rd_data, rd_v, shadow_q, act_q;
  logic [3:0] cur_nib = 4'hc, nib_q;
  tob_pcm_s   pcm_in, pcm_out, pin_q;
  // E-bit buffer differs from the pass-through data in both E frames
  tob_buf0_s  buf0 = '{8'h5a, 4'hc, 2'b10};
  tob_buf1_s  buf1 = '{8'h96, 8'h3c, 8'he1};
  int         fail_count = 0, check_count = 0;
  always #25 core_clk = ~core_clk;
  tob_pcm_source src (.core_clk(core_clk), .reset(reset), .pcm_in(pcm_in));
  tob_bit_select dut (.core_clk(core_clk), .reset(reset), .mpu_addr(mpu_addr),
    .mpu_wr_en(mpu_wr_en), .mpu_wr_data(mpu_wr_data), .mpu_rd_en(mpu_rd_en),
    .mpu_rd_data(mpu_rd_data), .bits_buf0(buf0), .bits_buf1(buf1),
    .rx_ebit_error(rx_ebit_error), .rx_crc_error(rx_crc_error), .pcm_in(pcm_in),
    .pcm_out(pcm_out));
  // Reference copy of the control register, applied only at multiframe starts
  always @(posedge core_clk)
  begin
    if (reset) shadow_q <= CTRL_A_RESET;
    else if (mpu_wr_en && mpu_addr == ADDR_CTRL_A) shadow_q <= mpu_wr_data;
    if (reset) act_q <= CTRL_A_RESET;
    else if (pcm_in.valid && pcm_in.ts0 && pcm_in[6:0] == 7'h00)
    begin
      act_q <= shadow_q;
      nib_q <= cur_nib;
    end
    pin_q <= pcm_in;
    crc_q <= rx_crc_error;
    rst_q <= reset;
  end
  function automatic logic expf();
    logic [2:0] i;
    i = pin_q.frame[3:1];
    expf = pin_q.data;
    if (pin_q.valid && pin_q.ts0 && pin_q.frame[0])
      case (pin_q.bitpos)
        TS0_SA4_BIT: if (act_q[0]) expf = buf1.sa4[i];
        TS0_SA5_BIT: if (act_q[1]) expf = buf0.sa5[i];
        TS0_SA6_BIT: if (act_q[3:2] == 2'b01) expf = buf0.sa6[3 - i[1:0]];
          else if (act_q[3:2] == 2'b10) expf = nib_q[3 - i[1:0]];
        TS0_SA7_BIT: if (act_q[4]) expf = buf1.sa7[i];
        TS0_SA8_BIT: if (act_q[5]) expf = buf1.sa8[i];
        TS0_SI_BIT: if (i >= 3'h6 && act_q[7:6] == 2'b01) expf = buf0.ebit[i[0]];
          else if (i >= 3'h6 && act_q[7:6] == 2'b10) expf = ~crc_q;
        default: ;
      endcase
  endfunction
  always @(negedge core_clk)
    if (rst_q) `CHK("pcm_out reset", 10'h000, pcm_out)
    else `CHK("pcm_out", {pin_q[9], expf(), pin_q[7:0]}, pcm_out)
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mpu_addr = a;
    mpu_wr_data = d;
    mpu_wr_en = 1'b1;
    @(negedge core_clk) mpu_wr_en = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    mpu_addr = a;
    mpu_rd_en = 1'b1;
    @(negedge core_clk) mpu_rd_en = 1'b0;
    d = mpu_rd_data;
    // An idle edge keeps a following read from re-raising the strobe at once
    @(negedge core_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    rd(ADDR_CTRL_A, rd_v); `CHK("ctrl_a reset", CTRL_A_RESET, rd_v)
    wr(ADDR_CTRL_B, 8'hff);
    rd(ADDR_CTRL_B, rd_v); `CHK("ctrl_b", 8'h7f, rd_v)
    wr(8'h44, 8'hff);
    rd(8'h44, rd_v); `CHK("unmapped", 8'h00, rd_v)
    rd(ADDR_INBAND, rd_v); `CHK("inband", 8'h00, rd_v)
    foreach (ROWS[r])
    begin
      {rx_crc_error, rx_ebit_error, cur_nib} = {ROWS[r].crc, ROWS[r].eerr, ROWS[r].nib};
      wr(ADDR_CTRL_A, ROWS[r].ctrl);
      rd(ADDR_CTRL_A, rd_v); `CHK("ctrl_a", ROWS[r].ctrl, rd_v)
      repeat (600) @(negedge core_clk);
      if (ROWS[r].ctrl == 8'h88)
      begin
        rd(ADDR_MON_A, rd_v); `CHK("monitor", {ROWS[r].nib, 2'b00, {2{~ROWS[r].crc}}}, rd_v)
      end
    end
    // Reset in mid-run must drop the illegal codes back to pass-through
    reset = 1'b1;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    rd(ADDR_CTRL_A, rd_v); `CHK("ctrl_a re-reset", CTRL_A_RESET, rd_v)
    repeat (300) @(negedge core_clk);
    give_verdict();
  end
endmodule
